// >>> eiosc_pkg.sv
// Overview of operation
// RULE1 - entry pushes registers, sets mask, loads vector
// RULE2 - return op pulls registers back from stack
// RULE3 - soft trap ignores global mask and enables
// RULE4 - mask set or enable clear blocks external
// RULE5 - sample latch only between instructions
// RULE6 - vector fetch clears external request latch
// RULE7 - pending request taken once return clears mask
// RULE8 - build option picks edge or edge-level sensing
// RULE9 - edge-level: low pin keeps request present
// RULE10 - edge-only: pin must rise before next fall
// RULE11 - port pins rising share the external latch
// RULE12 - port pins: high level or rising edge
// RULE13 - active pin blocks the other sources
// RULE14 - enable bit is read/write, one enables
// RULE15 - oscillator select pair drives clock enables
// RULE16 - reset sets enable and osc_sel_hi only
// RULE17 - flag read-only, set while request pending
// RULE18 - flag cleared by vector fetch or clear bit
// RULE19 - clear bit write-only, reads zero
// RULE20 - masked request waits until mask clears
// RULE21 - highest priority vector fetched first
// RULE22 - entry uses five stack locations
// RULE23 - push pcl, pch, x, a, ccr; pull reverse
package eiosc_pkg;
  localparam logic [3:0] EIOSC_ADDR_EXT_INT_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] EIOSC_ADDR_CPUCTL = 4'h4;
  localparam logic [3:0] EIOSC_ADDR_STACKCMD = 4'h8;
  localparam logic [3:0] EIOSC_ADDR_CPUSTAT = 4'hC;
  localparam int EIOSC_BIT_FLAG_CLEAR = 1;
  localparam int EIOSC_BIT_FLAG = 3;
  localparam int EIOSC_BIT_OSC_LO = 4;
  localparam int EIOSC_BIT_OSC_HI = 5;
  localparam int EIOSC_BIT_ENABLE = 7;
  localparam logic EIOSC_RST_ENABLE = 1'b1;
  localparam logic EIOSC_RST_OSC_HI = 1'b1;
  localparam logic EIOSC_RST_OSC_LO = 1'b0;
  localparam logic [7:0] EIOSC_RST_SP = 8'hFF;
  localparam logic [7:0] EIOSC_SP_FIXED_HI = 8'h00;
  localparam logic [1:0] EIOSC_SP_TOP = 2'h3;
  localparam logic [2:0] EIOSC_STACK_BYTES = 3'h5;
  localparam logic [15:0] EIOSC_VEC_SWI = 16'h1FFC;
  localparam logic [15:0] EIOSC_VEC_EXT = 16'h1FFA;
  localparam logic [2:0] EIOSC_PC_TOP = 3'h7;
  localparam logic [7:0] EIOSC_CCR_TOP = 8'hE0;
  localparam int EIOSC_CCR_MASK_BIT = 3;
  typedef enum logic [2:0] {
    EIOSC_IDLE, EIOSC_PUSH, EIOSC_VECHI, EIOSC_VECLO, EIOSC_PULL
  } eiosc_state_e;
endpackage

// >>> eiosc_sync.sv
`timescale 1ns/1ps
module eiosc_sync import eiosc_pkg::*; #(
  parameter int W = 5
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [1:0] primed;
  } eiosc_sync_s;
  eiosc_sync_s r_q, r_d;
  always_comb begin
    r_d = r_q;
    r_d.s1 = async_in;
    r_d.s2 = r_q.s1;
    r_d.primed = {r_q.primed[0], 1'b1};
  end
  // inactive levels until both stages hold a real sample
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end
  assign sync_out = r_q.primed[1] ? r_q.s2 : rst_val;
endmodule // eiosc_sync

// >>> eiosc_detect.sv
`timescale 1ns/1ps
module eiosc_detect import eiosc_pkg::*; #(
  parameter int NPORT = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic edge_level_mode,
  input wire logic port_int_opt,
  input wire logic ext_int_pin_s,
  input wire logic [NPORT-1:0] port_a_s,
  output logic req_event
);
  typedef struct packed {
    logic pin_prev;
    logic [NPORT-1:0] port_prev;
  } eiosc_det_s;
  eiosc_det_s r_q, r_d;
  logic port_any, pin_fall, port_rise, pin_act, port_act;
  always_comb begin
    r_d = r_q;
    r_d.pin_prev = ext_int_pin_s;
    r_d.port_prev = port_a_s;
    port_any = port_int_opt && (|port_a_s);
    // active pin blocks the other sources
    pin_fall = r_q.pin_prev && !ext_int_pin_s && !port_any; // RULE10 RULE13
    port_rise = port_int_opt && (|(port_a_s & ~r_q.port_prev)) && ext_int_pin_s; // RULE11 RULE13
    pin_act = pin_fall || (edge_level_mode && !ext_int_pin_s && !port_any); // RULE8 RULE9
    port_act = port_rise || (edge_level_mode && port_any && ext_int_pin_s); // RULE12
    req_event = pin_act || port_act;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{pin_prev: 1'b1, port_prev: '0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end
endmodule // eiosc_detect

// >>> eiosc_top.sv
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module eiosc_top import eiosc_pkg::*; #(
  parameter bit EDGE_LEVEL = 1'b1,
  parameter bit PORT_INT = 1'b1,
  parameter int NPORT = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic ext_int_pin,
  input wire logic [NPORT-1:0] port_a_int_pins,
  input wire logic instr_done,
  input wire logic soft_trap_op,
  input wire logic trap_return_op,
  input wire logic [15:0] cpu_pc,
  input wire logic [7:0] cpu_x,
  input wire logic [7:0] cpu_a,
  input wire logic [7:0] cpu_ccr,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic stk_we,
  output logic stk_re,
  output logic [15:0] stk_addr,
  output logic [7:0] stk_wdata,
  input wire logic [7:0] stk_rdata,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic ccr_load,
  output logic [7:0] ccr_value,
  output logic x_load,
  output logic [7:0] x_value,
  output logic a_load,
  output logic [7:0] a_value,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_rdata,
  output logic cpu_hold,
  output logic ext_int_flag,
  output logic cpu_clk_int_sel,
  output logic low_power_osc_en,
  output logic pin_osc_en
);
  typedef struct packed {
    eiosc_state_e st;
    logic [2:0] cnt;
    logic is_soft;
    logic [7:0] sp;
    logic [7:0] vhi;
    logic enable;
    logic osc_hi;
    logic osc_lo;
    logic flag;
    logic [31:0] rdata;
    logic wait_n;
    logic stk_we;
    logic stk_re;
    logic [15:0] stk_addr;
    logic [7:0] stk_wdata;
    logic pc_load;
    logic [15:0] pc_value;
    logic ccr_load;
    logic [7:0] ccr_value;
    logic x_load;
    logic [7:0] x_value;
    logic a_load;
    logic [7:0] a_value;
    logic vec_rd;
    logic [15:0] vec_addr;
    logic hold;
    logic pull_wait;
    logic clk_int;
    logic lpo_en;
    logic epo_en;
    logic [15:0] pc_pull;
  } eiosc_top_s;

  eiosc_top_s r_q, r_d;
  logic pin_s;
  logic [NPORT-1:0] port_s;
  logic req_event;
  logic wr_ext_int_status_control, rd_hit, is_mapped, ext_go, mask_i;

  function automatic logic [7:0] eiosc_push_byte(input logic [2:0] idx,
      input logic [15:0] pc, input logic [7:0] x, input logic [7:0] a,
      input logic [7:0] cond_code_reg);
    case (idx)
      3'h0: eiosc_push_byte = pc[7:0];
      3'h1: eiosc_push_byte = {EIOSC_PC_TOP, pc[12:8]};
      3'h2: eiosc_push_byte = x;
      3'h3: eiosc_push_byte = a;
      default: eiosc_push_byte = cond_code_reg | EIOSC_CCR_TOP;
    endcase
  endfunction

  function automatic logic [15:0] eiosc_sp_addr(input logic [7:0] sp);
    eiosc_sp_addr = {EIOSC_SP_FIXED_HI, EIOSC_SP_TOP, sp[5:0]};
  endfunction

  eiosc_sync #(.W(NPORT + 1)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({ext_int_pin, port_a_int_pins}),
    .rst_val({1'b1, {NPORT{1'b0}}}),
    .sync_out({pin_s, port_s})
  );

  eiosc_detect #(.NPORT(NPORT)) u_det (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .edge_level_mode(EDGE_LEVEL),
    .port_int_opt(PORT_INT),
    .ext_int_pin_s(pin_s),
    .port_a_s(port_s),
    .req_event(req_event)
  );

  always_comb begin
    r_d = r_q;
    r_d.stk_we = 1'b0;
    r_d.stk_re = 1'b0;
    r_d.pc_load = 1'b0;
    r_d.ccr_load = 1'b0;
    r_d.x_load = 1'b0;
    r_d.a_load = 1'b0;
    r_d.vec_rd = 1'b0;
    r_d.wait_n = 1'b0;
    r_d.pull_wait = 1'b0;
    is_mapped = (avs_address == EIOSC_ADDR_EXT_INT_STATUS_CONTROL);
    wr_ext_int_status_control = avs_write && is_mapped && avs_byteenable[0] && r_q.wait_n;
    rd_hit = avs_read && !r_q.wait_n;
    mask_i = cpu_ccr[EIOSC_CCR_MASK_BIT];
    // latch gated only at instruction boundary, held while masked
    ext_go = instr_done && r_q.flag && !mask_i && r_q.enable; // RULE4 RULE5 RULE7 RULE20
    // bus: one wait cycle then answer
    if ((avs_read || avs_write) && !r_q.wait_n) begin
      r_d.wait_n = 1'b1;
    end
    if (rd_hit) begin
      r_d.rdata = '0;
      if (is_mapped) begin
        r_d.rdata[EIOSC_BIT_ENABLE] = r_q.enable; // RULE14
        r_d.rdata[EIOSC_BIT_OSC_HI] = r_q.osc_hi;
        r_d.rdata[EIOSC_BIT_OSC_LO] = r_q.osc_lo;
        r_d.rdata[EIOSC_BIT_FLAG] = r_q.flag; // RULE17
        r_d.rdata[EIOSC_BIT_FLAG_CLEAR] = 1'b0; // RULE19
      end
    end
    if (wr_ext_int_status_control) begin
      r_d.enable = avs_writedata[EIOSC_BIT_ENABLE]; // RULE14
      r_d.osc_hi = avs_writedata[EIOSC_BIT_OSC_HI];
      r_d.osc_lo = avs_writedata[EIOSC_BIT_OSC_LO];
      if (avs_writedata[EIOSC_BIT_FLAG_CLEAR]) begin
        r_d.flag = 1'b0; // RULE18 RULE19
      end
    end
    // oscillator enables follow the select pair
    r_d.clk_int = !(!r_q.osc_hi && r_q.osc_lo); // RULE15
    r_d.epo_en = r_q.osc_lo; // RULE15
    r_d.lpo_en = !(!r_q.osc_hi && r_q.osc_lo);
    case (r_q.st)
      EIOSC_IDLE: begin
        r_d.hold = 1'b0;
        // soft trap first: same priority as the instruction, unmaskable
        if (soft_trap_op) begin
          r_d.st = EIOSC_PUSH; // RULE3
          r_d.is_soft = 1'b1;
          r_d.cnt = '0;
          r_d.hold = 1'b1;
        end else if (trap_return_op) begin
          r_d.st = EIOSC_PULL; // RULE2
          r_d.cnt = '0;
          r_d.hold = 1'b1;
          r_d.stk_re = 1'b1;
          r_d.sp = r_q.sp + 8'h01;
          r_d.stk_addr = eiosc_sp_addr(r_q.sp + 8'h01);
        end else if (ext_go) begin
          r_d.st = EIOSC_PUSH; // RULE21
          r_d.is_soft = 1'b0;
          r_d.cnt = '0;
          r_d.hold = 1'b1;
        end
      end
      EIOSC_PUSH: begin
        // push pcl, pch, x, a, ccr, five bytes
        r_d.stk_we = 1'b1; // RULE1 RULE22 RULE23
        r_d.stk_addr = eiosc_sp_addr(r_q.sp);
        r_d.stk_wdata = eiosc_push_byte(r_q.cnt, cpu_pc, cpu_x, cpu_a, cpu_ccr);
        r_d.sp = r_q.sp - 8'h01;
        r_d.cnt = r_q.cnt + 3'h1;
        if (r_q.cnt == EIOSC_STACK_BYTES - 3'h1) begin
          r_d.st = EIOSC_VECHI;
          r_d.ccr_load = 1'b1;
          r_d.ccr_value = cpu_ccr | EIOSC_CCR_TOP;
          r_d.ccr_value[EIOSC_CCR_MASK_BIT] = 1'b1; // RULE1
          r_d.vec_rd = 1'b1;
          r_d.vec_addr = r_q.is_soft ? EIOSC_VEC_SWI : EIOSC_VEC_EXT;
          if (!r_q.is_soft) begin
            r_d.flag = 1'b0; // RULE6 RULE18
          end
        end
      end
      EIOSC_VECHI: begin
        // vector byte arrives one cycle after the strobe
        if (!r_q.pull_wait) begin
          r_d.pull_wait = 1'b1;
        end else begin
          r_d.vhi = vec_rdata;
          r_d.vec_rd = 1'b1;
          r_d.vec_addr = r_q.vec_addr + 16'h0001;
          r_d.st = EIOSC_VECLO;
        end
      end
      EIOSC_VECLO: begin
        if (!r_q.pull_wait) begin
          r_d.pull_wait = 1'b1;
        end else begin
          r_d.pc_load = 1'b1; // RULE1
          r_d.pc_value = {r_q.vhi, vec_rdata};
          r_d.st = EIOSC_IDLE;
          r_d.hold = 1'b0;
        end
      end
      EIOSC_PULL: begin
        // pull ccr, a, x, pch, pcl, one byte per two cycles
        if (!r_q.pull_wait && !r_q.stk_re) begin
          r_d.stk_re = 1'b1;
          r_d.sp = r_q.sp + 8'h01;
          r_d.stk_addr = eiosc_sp_addr(r_q.sp + 8'h01);
        end else if (r_q.stk_re) begin
          r_d.pull_wait = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt + 3'h1;
          case (r_q.cnt)
            3'h0: begin
              r_d.ccr_load = 1'b1; // RULE23 RULE7
              r_d.ccr_value = stk_rdata | EIOSC_CCR_TOP;
            end
            3'h1: begin
              r_d.a_load = 1'b1;
              r_d.a_value = stk_rdata;
            end
            3'h2: begin
              r_d.x_load = 1'b1;
              r_d.x_value = stk_rdata;
            end
            3'h3: r_d.pc_pull[15:8] = {EIOSC_PC_TOP, stk_rdata[4:0]};
            default: begin
              r_d.pc_load = 1'b1; // RULE2
              r_d.pc_value = {r_q.pc_pull[15:8], stk_rdata};
              r_d.st = EIOSC_IDLE;
              r_d.hold = 1'b0;
            end
          endcase
          if (r_q.cnt == EIOSC_STACK_BYTES - 3'h1) begin
            r_d.stk_re = 1'b0;
          end else begin
            r_d.stk_re = 1'b1;
            r_d.sp = r_q.sp + 8'h01;
            r_d.stk_addr = eiosc_sp_addr(r_q.sp + 8'h01);
          end
        end
      end
      default: r_d.st = EIOSC_IDLE;
    endcase
    // new event wins over any clear
    if (req_event) begin
      r_d.flag = 1'b1; // RULE9 RULE17
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
      r_q.st <= EIOSC_IDLE;
      r_q.sp <= EIOSC_RST_SP;
      r_q.enable <= EIOSC_RST_ENABLE; // RULE16
      r_q.osc_hi <= EIOSC_RST_OSC_HI; // RULE16
      r_q.osc_lo <= EIOSC_RST_OSC_LO;
      r_q.clk_int <= 1'b1;
      r_q.lpo_en <= 1'b1;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign avs_readdata = r_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !r_q.wait_n;
  assign stk_we = r_q.stk_we;
  assign stk_re = r_q.stk_re;
  assign stk_addr = r_q.stk_addr;
  assign stk_wdata = r_q.stk_wdata;
  assign pc_load = r_q.pc_load;
  assign pc_value = r_q.pc_value;
  assign ccr_load = r_q.ccr_load;
  assign ccr_value = r_q.ccr_value;
  assign x_load = r_q.x_load;
  assign x_value = r_q.x_value;
  assign a_load = r_q.a_load;
  assign a_value = r_q.a_value;
  assign vec_rd = r_q.vec_rd;
  assign vec_addr = r_q.vec_addr;
  assign cpu_hold = r_q.hold;
  assign ext_int_flag = r_q.flag;
  assign cpu_clk_int_sel = r_q.clk_int;
  assign low_power_osc_en = r_q.lpo_en;
  assign pin_osc_en = r_q.epo_en;
endmodule // eiosc_top

// >>> eiosc_chk.sv
`timescale 1ns/1ps
module eiosc_chk import eiosc_pkg::*; #(
  parameter int NPORT = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic ext_int_pin,
  input wire logic [NPORT-1:0] port_a_int_pins,
  input wire logic instr_done,
  input wire logic soft_trap_op,
  input wire logic trap_return_op,
  input wire logic [7:0] cpu_ccr,
  input wire logic stk_we,
  input wire logic stk_re,
  input wire logic [15:0] stk_addr,
  input wire logic ccr_load,
  input wire logic [7:0] ccr_value,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic cpu_hold,
  input wire logic ext_int_flag,
  input wire logic cpu_clk_int_sel,
  input wire logic low_power_osc_en,
  input wire logic pin_osc_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_push_five: assert property ($rose(stk_we) |-> stk_we [*5] ##1 !stk_we)
    else $error("entry push count wrong");
  a_stack_range: assert property (stk_we || stk_re |-> stk_addr[15:6] == 10'h003)
    else $error("stack address out of range");
  a_mask_entry: assert property (vec_rd && !vec_addr[0] |-> ccr_load && ccr_value[3])
    else $error("mask not set at vector fetch");
  a_vec_clear: assert property (vec_rd && vec_addr == EIOSC_VEC_EXT && ext_int_pin
    && port_a_int_pins == '0 |=> !ext_int_flag)
    else $error("flag not cleared by vector fetch");
  a_mask_gate: assert property (instr_done && cpu_ccr[3] && !soft_trap_op
    && !trap_return_op && !cpu_hold |=> !stk_we && !cpu_hold)
    else $error("masked external request serviced");
  a_trap_go: assert property (soft_trap_op && !cpu_hold |-> ##[1:3] stk_we)
    else $error("soft trap not started");
  a_return_pull: assert property (trap_return_op && !soft_trap_op && !cpu_hold |-> ##[1:3] stk_re)
    else $error("return did not pull stack");
  a_osc_pair: assert property (cpu_clk_int_sel == low_power_osc_en && (low_power_osc_en || pin_osc_en))
    else $error("oscillator enables inconsistent");
  c_ext: cover property (vec_rd && vec_addr == EIOSC_VEC_EXT);
  c_soft: cover property (vec_rd && vec_addr == EIOSC_VEC_SWI);
  c_ret: cover property (stk_re);
endmodule // eiosc_chk

bind eiosc_top eiosc_chk #(.NPORT(NPORT)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .ext_int_pin(ext_int_pin), .port_a_int_pins(port_a_int_pins), .instr_done(instr_done),
  .soft_trap_op(soft_trap_op), .trap_return_op(trap_return_op), .cpu_ccr(cpu_ccr),
  .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr), .ccr_load(ccr_load),
  .ccr_value(ccr_value), .vec_rd(vec_rd), .vec_addr(vec_addr), .cpu_hold(cpu_hold),
  .ext_int_flag(ext_int_flag), .cpu_clk_int_sel(cpu_clk_int_sel),
  .low_power_osc_en(low_power_osc_en), .pin_osc_en(pin_osc_en));

// >>> eiosc_src.sv
`timescale 1ns/1ps
module eiosc_src (
  input wire logic [1:0] pin_pull,
  input wire logic [3:0] port_drive,
  output logic ext_int_pin,
  output logic [3:0] port_a_int_pins
);
  // wired-or sources, pull-up when all release
  assign ext_int_pin = ~|pin_pull;
  // port lines pulled down when undriven
  assign port_a_int_pins = port_drive;
endmodule // eiosc_src

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import eiosc_pkg::*;
  localparam logic [11:0] OSC_TAB = 12'hC77;
  localparam logic [39:0] STK = 40'h34F25678E0;
  logic ref_clk = 0, rst_b = 0, instr_done = 0, soft_trap_op = 0, trap_return_op = 0;
  logic avs_read = 0, avs_write = 0, ext_int_pin, stk_we, stk_re, pc_load, vec_rd;
  logic avs_waitrequest, ext_int_flag, cpu_clk_int_sel, low_power_osc_en, pin_osc_en;
  logic [1:0] pin_pull = 0;
  logic [3:0] port_drive = 0, avs_address = 0, port_a_int_pins;
  logic [15:0] cpu_pc = 16'h1234, stk_addr, pc_value, vec_addr;
  logic [7:0] cpu_x = 8'h56, cpu_a = 8'h78, cpu_ccr = 8'hE0, stk_rdata = 0, vec_rdata = 0;
  logic [7:0] stk_wdata, a_value, x_value, a_got = 0, x_got = 0;
  logic a_load, x_load, flag_e;
  logic [7:0] mem [0:63];
  logic [31:0] avs_writedata = 0, avs_readdata, rdat;
  int err_count = 0, checks = 0, cyc = 0;
  eiosc_src u_src (.pin_pull(pin_pull), .port_drive(port_drive), .ext_int_pin(ext_int_pin),
    .port_a_int_pins(port_a_int_pins));
  eiosc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .ext_int_pin(ext_int_pin),
    .port_a_int_pins(port_a_int_pins), .instr_done(instr_done), .soft_trap_op(soft_trap_op),
    .trap_return_op(trap_return_op), .cpu_pc(cpu_pc), .cpu_x(cpu_x), .cpu_a(cpu_a),
    .cpu_ccr(cpu_ccr), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .pc_load(pc_load), .pc_value(pc_value),
    .ccr_load(), .ccr_value(), .x_load(x_load), .x_value(x_value), .a_load(a_load),
    .a_value(a_value), .vec_rd(vec_rd),
    .vec_addr(vec_addr), .vec_rdata(vec_rdata), .cpu_hold(), .ext_int_flag(ext_int_flag),
    .cpu_clk_int_sel(cpu_clk_int_sel), .low_power_osc_en(low_power_osc_en),
    .pin_osc_en(pin_osc_en));
  // edge-only build, same stimulus, only its flag is watched
  eiosc_top #(.EDGE_LEVEL(1'b0)) dut_e (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
    .ext_int_pin(ext_int_pin), .port_a_int_pins(port_a_int_pins), .instr_done(instr_done),
    .soft_trap_op(soft_trap_op), .trap_return_op(trap_return_op), .cpu_pc(cpu_pc),
    .cpu_x(cpu_x), .cpu_a(cpu_a), .cpu_ccr(cpu_ccr), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(), .avs_waitrequest(), .stk_we(), .stk_re(),
    .stk_addr(), .stk_wdata(), .stk_rdata(stk_rdata), .pc_load(), .pc_value(), .ccr_load(),
    .ccr_value(), .x_load(), .x_value(), .a_load(), .a_value(), .vec_rd(), .vec_addr(),
    .vec_rdata(vec_rdata), .cpu_hold(), .ext_int_flag(flag_e), .cpu_clk_int_sel(),
    .low_power_osc_en(), .pin_osc_en());
  always #2.5 ref_clk = ~ref_clk;
  // stack ram and vector rom stand-in, garbage when not answering
  always @(posedge ref_clk) begin
    if (stk_we) mem[stk_addr[5:0]] <= stk_wdata;
    stk_rdata <= stk_re ? mem[stk_addr[5:0]] : ~stk_rdata;
    vec_rdata <= vec_rd ? vec_addr[7:0] : ~vec_rdata;
    if (a_load) a_got <= a_value;
    if (x_load) x_got <= x_value;
  end
  task automatic give_verdict;
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic we, input logic [3:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= wd;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] exp);
    acc(1'b0, ad, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    instr_done <= (k == 0);
    soft_trap_op <= (k == 1);
    trap_return_op <= (k == 2);
    @(posedge ref_clk);
    {instr_done, soft_trap_op, trap_return_op} <= 3'h0;
  endtask
  task automatic fall(input logic [1:0] who);
    @(posedge ref_clk);
    pin_pull <= who;
    repeat (3) @(posedge ref_clk);
    pin_pull <= 2'h0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic wait_pc(input logic [15:0] exp);
    do begin
      @(posedge ref_clk);
    end while (pc_load !== 1'b1);
    chk({16'h0000, pc_value}, {16'h0000, exp});
  endtask
  initial begin
    mem[58] = 8'h5A;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(4'h0, 32'hA0);
    chk({29'h0, cpu_clk_int_sel, low_power_osc_en, pin_osc_en}, 32'h6);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 4'h0, 32'h80 | 32'(i << 4));
      rd(4'h0, 32'h80 | 32'(i << 4));
      chk({29'h0, cpu_clk_int_sel, low_power_osc_en, pin_osc_en},
        {29'h0, 3'(OSC_TAB >> (9 - 3 * i))});
    end
    acc(1'b1, 4'h0, 32'hAA);
    rd(4'h0, 32'hA0);
    rd(4'h4, 32'h0);
    fall(2'h3);
    rd(4'h0, 32'hA8);
    acc(1'b1, 4'h0, 32'hA2);
    rd(4'h0, 32'hA0);
    fall(2'h1);
    cpu_ccr <= 8'hE8;
    pulse(0);
    rd(4'h0, 32'hA8);
    acc(1'b1, 4'h0, 32'h28);
    cpu_ccr <= 8'hE0;
    pulse(0);
    rd(4'h0, 32'h28);
    acc(1'b1, 4'h0, 32'hA0);
    pulse(0);
    wait_pc(16'hFAFB);
    cpu_ccr <= 8'hE8;
    for (int j = 0; j < 5; j++) chk({24'h0, mem[63 - j]}, {24'h0, STK[39 - 8 * j -: 8]});
    chk({24'h0, mem[58]}, 32'h5A);
    rd(4'h0, 32'hA0);
    fall(2'h2);
    rd(4'h0, 32'hA8);
    pulse(2);
    wait_pc(16'hF234);
    chk({24'h0, a_got}, 32'h78);
    chk({24'h0, x_got}, 32'h56);
    cpu_ccr <= 8'hE0;
    pulse(0);
    wait_pc(16'hFAFB);
    cpu_ccr <= 8'hE8;
    pulse(1);
    wait_pc(16'hFCFD);
    @(posedge ref_clk);
    port_drive <= 4'h4;
    repeat (3) @(posedge ref_clk);
    port_drive <= 4'h0;
    repeat (6) @(posedge ref_clk);
    rd(4'h0, 32'hA8);
    pin_pull <= 2'h1;
    repeat (6) @(posedge ref_clk);
    acc(1'b1, 4'h0, 32'hA2);
    @(posedge ref_clk);
    chk({31'h0, ext_int_flag}, 32'h1);
    chk({31'h0, flag_e}, 32'h0);
    pin_pull <= 2'h0;
    repeat (2) @(posedge ref_clk);
    pin_pull <= 2'h1;
    repeat (5) @(posedge ref_clk);
    chk({31'h0, flag_e}, 32'h1);
    pin_pull <= 2'h0;
    give_verdict;
  end
endmodule // tb
